// file: core/iwd_decoder.sv
// Instruction decoder with four-phase cycle sequencing and read-modify-write strobes.
`timescale 1ns/100ps
//
// Contract
// - Each 14-bit word is split into an operation part and operand fields.
// - Every word is sorted into byte, bit or literal/control format.
// - A byte operation with destination 0 writes the accumulator, except operation code 0, which writes neither; with 1 it writes the file register.
// - The file address is seven bits, selecting registers 0x00 to 0x7f.
// - A bit operation touches only the one selected bit of the 8-bit register.
// - The literal is decoded as 8 bits, or 11 bits for jump and call targets.
// - One instruction cycle spans four oscillator periods and advances one instruction.
// - A taken test or a program counter change costs a second cycle that runs as a no-operation.
// - Any instruction naming a file register reads it before storing, even when it only writes.
// - Clearing a port therefore reads the port and clears the port-change mismatch.
// - Don't-care bits are ignored so either value gives the same operation.
// - A port register modified from itself reads the pin levels, not the latch.
// - A write to the timer zero count clears the prescaler when it is assigned to that timer.
module iwd_decoder
  import iwd_pkg::*;
#(
  parameter logic [iwd_pkg::FADDR_W-1:0] TIMER_ZERO_ADDR = 7'h01,
  parameter logic [iwd_pkg::FADDR_W-1:0] PC_LOW_ADDR = 7'h02,
  parameter logic [iwd_pkg::FADDR_W-1:0] IO_FIRST_ADDR = 7'h05,
  parameter logic [iwd_pkg::FADDR_W-1:0] IO_LAST_ADDR = 7'h09
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Program memory and datapath inputs
  input wire logic [iwd_pkg::INSN_W-1:0] insnWord,
  input wire logic skipTaken,
  input wire logic prescToTimer,
  // Decoded fields
  output iwd_pkg::iwd_fmt_t fmt,
  output logic [iwd_pkg::INSN_W-1:0] normWord,
  output logic [iwd_pkg::FADDR_W-1:0] fileAddr,
  output logic destSel,
  output logic [iwd_pkg::BIT_W-1:0] bitSel,
  output logic [iwd_pkg::DATA_W-1:0] bitMask,
  output logic [iwd_pkg::LIT8_W-1:0] lit8,
  output logic [iwd_pkg::LIT11_W-1:0] lit11,
  // Sequencing strobes
  output iwd_pkg::iwd_phase_t phase,
  output logic fileRdStrb,
  output logic readPins,
  output logic fileWrStrb,
  output logic accWrStrb,
  output logic statusWrStrb,
  output logic pcLoad,
  output logic prescClr,
  output logic fetchStrb,
  output logic nopCycle
);

  typedef struct packed {
    iwd_phase_t phase;
    logic [INSN_W-1:0] insn;
    logic nopCycle;
    logic nopNext;
    iwd_fmt_t fmt;
    logic [INSN_W-1:0] normWord;
    logic [FADDR_W-1:0] fileAddr;
    logic destSel;
    logic [BIT_W-1:0] bitSel;
    logic [DATA_W-1:0] bitMask;
    logic [LIT8_W-1:0] lit8;
    logic [LIT11_W-1:0] lit11;
    logic fileRdStrb;
    logic readPins;
    logic fileWrStrb;
    logic accWrStrb;
    logic statusWrStrb;
    logic pcLoad;
    logic prescClr;
    logic fetchStrb;
  } iwd_state_t;

  // After reset the first cycle is a flush, so the word already on the bus is fetched cleanly.
  localparam iwd_state_t RST_STATE = '{phase: PH_Q1, nopCycle: 1'b1, fmt: FMT_BYTE, default: '0};

  iwd_state_t st_ff;
  iwd_state_t nxt_st;
  iwd_fmt_t dFmt;
  logic [INSN_W-1:0] dNorm;
  logic [FADDR_W-1:0] dAddr;
  logic dDest;
  logic [BIT_W-1:0] dBit;
  logic [LIT8_W-1:0] dLit8;
  logic [LIT11_W-1:0] dLit11;
  logic dNames;
  logic dWrFile;
  logic dWrAcc;
  logic dStatus;
  logic dSkip;
  logic dJump;
  logic pcWrite;
  logic isIo;

  iwd_field_split u_split (
    .word(st_ff.insn),
    .fmt(dFmt),
    .normWord(dNorm),
    .fileAddr(dAddr),
    .destSel(dDest),
    .bitSel(dBit),
    .lit8(dLit8),
    .lit11(dLit11),
    .namesFile(dNames),
    .writesFile(dWrFile),
    .writesAcc(dWrAcc),
    .affectsStatus(dStatus),
    .isSkip(dSkip),
    .changesPc(dJump)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    pcWrite = dWrFile && (dAddr == PC_LOW_ADDR);
    isIo = (dAddr >= IO_FIRST_ADDR) && (dAddr <= IO_LAST_ADDR);
    nxt_st.phase = iwd_phase_t'(st_ff.phase + 2'd1);
    nxt_st.fileRdStrb = 1'b0;
    nxt_st.readPins = 1'b0;
    nxt_st.fileWrStrb = 1'b0;
    nxt_st.accWrStrb = 1'b0;
    nxt_st.statusWrStrb = 1'b0;
    nxt_st.pcLoad = 1'b0;
    nxt_st.prescClr = 1'b0;
    nxt_st.fetchStrb = 1'b0;
    case (st_ff.phase)
      PH_Q1: begin
        nxt_st.fmt = dFmt;
        nxt_st.normWord = dNorm;
        nxt_st.fileAddr = dAddr;
        nxt_st.destSel = dDest;
        nxt_st.bitSel = dBit;
        nxt_st.bitMask = BIT_ONE << dBit;
        nxt_st.lit8 = dLit8;
        nxt_st.lit11 = dLit11;
        // forced read of any named file
        nxt_st.fileRdStrb = dNames && !st_ff.nopCycle;
        // port reads come from the pins
        nxt_st.readPins = dNames && isIo && !st_ff.nopCycle;
      end
      PH_Q2: begin
      end
      PH_Q3: begin
        // writes suppressed in the flush cycle
        nxt_st.fileWrStrb = dWrFile && !st_ff.nopCycle;
        nxt_st.accWrStrb = dWrAcc && !st_ff.nopCycle;
        nxt_st.statusWrStrb = dStatus && !st_ff.nopCycle;
        nxt_st.pcLoad = (dJump || pcWrite) && !st_ff.nopCycle;
        // timer zero write clears its prescaler
        nxt_st.prescClr = dWrFile && (dAddr == TIMER_ZERO_ADDR) && prescToTimer && !st_ff.nopCycle;
        // second cycle on a change of flow or a taken test
        nxt_st.nopNext = !st_ff.nopCycle && (dJump || pcWrite || (dSkip && skipTaken));
        nxt_st.fetchStrb = 1'b1;
      end
      PH_Q4: begin
        nxt_st.insn = insnWord;
        nxt_st.nopCycle = st_ff.nopNext;
        nxt_st.nopNext = 1'b0;
      end
      default: begin
        nxt_st = RST_STATE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= RST_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  assign fmt = st_ff.fmt;
  assign normWord = st_ff.normWord;
  assign fileAddr = st_ff.fileAddr;
  assign destSel = st_ff.destSel;
  assign bitSel = st_ff.bitSel;
  assign bitMask = st_ff.bitMask;
  assign lit8 = st_ff.lit8;
  assign lit11 = st_ff.lit11;
  assign phase = st_ff.phase;
  assign fileRdStrb = st_ff.fileRdStrb;
  assign readPins = st_ff.readPins;
  assign fileWrStrb = st_ff.fileWrStrb;
  assign accWrStrb = st_ff.accWrStrb;
  assign statusWrStrb = st_ff.statusWrStrb;
  assign pcLoad = st_ff.pcLoad;
  assign prescClr = st_ff.prescClr;
  assign fetchStrb = st_ff.fetchStrb;
  assign nopCycle = st_ff.nopCycle;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  cycle_period_a: assert property (fetchStrb |=> !fetchStrb [*3] ##1 fetchStrb)
    else $error("fetch strobe not every four clocks");
  read_in_q2_a: assert property (fileRdStrb |-> phase == PH_Q2)
    else $error("file read outside second phase");
  read_before_wr_a: assert property (fileWrStrb && fmt != FMT_LIT |-> $past(fileRdStrb, 2))
    else $error("file write without preceding read");
  flush_quiet_a: assert property (nopCycle |-> !(fileWrStrb || accWrStrb || statusWrStrb || fileRdStrb))
    else $error("write during flush cycle");
  flush_follows_a: assert property (pcLoad |=> nopCycle [*4])
    else $error("program counter change not followed by flush cycle");
  dest_file_a: assert property (fileWrStrb && fmt == FMT_BYTE |-> destSel)
    else $error("byte file write with accumulator destination");
  dest_acc_a: assert property (accWrStrb && fmt == FMT_BYTE |-> !destSel && !fileWrStrb)
    else $error("byte accumulator write with file destination");
  presc_clear_a: assert property (prescClr |-> fileWrStrb && fileAddr == TIMER_ZERO_ADDR && $past(prescToTimer))
    else $error("prescaler cleared without timer write");
  pin_read_a: assert property (readPins |-> fileRdStrb && fileAddr >= IO_FIRST_ADDR && fileAddr <= IO_LAST_ADDR)
    else $error("pin read outside port read");
  one_bit_a: assert property (phase == PH_Q3 |-> $onehot(bitMask) && bitMask[bitSel])
    else $error("bit mask not single selected bit");
  lit_split_a: assert property (phase == PH_Q2 |-> lit8 == normWord[LIT8_W-1:0] && lit11 == normWord[LIT11_W-1:0])
    else $error("literal fields mismatch");

  skip_taken_c: cover property (fileRdStrb ##2 (!pcLoad && !nopCycle) ##1 nopCycle);
  jump_c: cover property (pcLoad ##1 nopCycle);
  port_clear_c: cover property (readPins ##2 fileWrStrb);
endmodule

// file: core/iwd_pkg.sv
// Shared constants and types for the instruction word decoder.
package iwd_pkg;
  localparam int INSN_W = 14;
  localparam int FADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  localparam int BIT_W = 3;
  localparam int OP_W = 4;
  // Field positions within the instruction word.
  localparam int FMT_HI = 13;
  localparam int FMT_LO = 12;
  localparam int OP_HI = 11;
  localparam int OP_LO = 8;
  localparam int D_POS = 7;
  localparam int FA_HI = 6;
  localparam int BIT_HI = 9;
  localparam int BIT_LO = 7;
  localparam int BIT_TEST_POS = 11;
  localparam int NOP_LOW_HI = 4;
  localparam int X_NOP_HI = 6;
  localparam int X_NOP_LO = 5;
  localparam int X_LIT_HI = 9;
  localparam int X_LIT_LO = 8;
  // Top two bits of the word.
  localparam logic [1:0] TOP_BYTE = 2'h0;
  localparam logic [1:0] TOP_BIT = 2'h1;
  localparam logic [1:0] TOP_JUMP = 2'h2;
  localparam logic [1:0] TOP_LIT = 2'h3;
  // Operation codes that the decoder must tell apart.
  localparam logic [OP_W-1:0] OPB_MISC = 4'h0;
  localparam logic [OP_W-1:0] OPB_CLR = 4'h1;
  localparam logic [OP_W-1:0] OPB_DECSZ = 4'hb;
  localparam logic [OP_W-1:0] OPB_SWAP = 4'he;
  localparam logic [OP_W-1:0] OPB_INCSZ = 4'hf;
  localparam logic [OP_W-1:0] OPL_PAIR_MASK = 4'hc;
  localparam logic [OP_W-1:0] OPL_ONE_MASK = 4'he;
  localparam logic [OP_W-1:0] OPL_MOVE = 4'h0;
  localparam logic [OP_W-1:0] OPL_RETL = 4'h4;
  localparam logic [OP_W-1:0] OPL_SUBL = 4'hc;
  localparam logic [OP_W-1:0] OPL_ADDL = 4'he;
  localparam logic [INSN_W-1:0] WORD_RETURN = 14'h0008;
  localparam logic [INSN_W-1:0] WORD_RETINT = 14'h0009;
  localparam logic [INSN_W-1:0] WORD_SLEEP = 14'h0063;
  localparam logic [INSN_W-1:0] WORD_WDTCLR = 14'h0064;
  localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;
  // Oscillator periods per instruction cycle; the core clock is the oscillator.
  localparam int OSC_PER_CYCLE = 4;
  typedef enum logic [1:0] {
    FMT_BYTE = 2'b00,
    FMT_BIT = 2'b01,
    FMT_LIT = 2'b10
  } iwd_fmt_t;
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } iwd_phase_t;
endpackage

// file: core/iwd_field_split.sv
// Combinational split of one instruction word into format, fields and class flags.
`timescale 1ns/100ps
module iwd_field_split
  import iwd_pkg::*;
(
  // Raw word
  input wire logic [iwd_pkg::INSN_W-1:0] word,
  // Fields
  output iwd_pkg::iwd_fmt_t fmt,
  output logic [iwd_pkg::INSN_W-1:0] normWord,
  output logic [iwd_pkg::FADDR_W-1:0] fileAddr,
  output logic destSel,
  output logic [iwd_pkg::BIT_W-1:0] bitSel,
  output logic [iwd_pkg::LIT8_W-1:0] lit8,
  output logic [iwd_pkg::LIT11_W-1:0] lit11,
  // Class flags
  output logic namesFile,
  output logic writesFile,
  output logic writesAcc,
  output logic affectsStatus,
  output logic isSkip,
  output logic changesPc
);
  logic [1:0] top;
  logic [OP_W-1:0] op;
  logic isMisc;

  always_comb begin
    top = word[FMT_HI:FMT_LO];
    op = word[OP_HI:OP_LO];
    if (top == TOP_BYTE) begin
      fmt = FMT_BYTE;
    end else if (top == TOP_BIT) begin
      fmt = FMT_BIT;
    end else begin
      fmt = FMT_LIT;
    end
    // don't-care bits forced to zero so either value decodes alike
    normWord = word;
    isMisc = (top == TOP_BYTE) && (op == OPB_MISC) && !word[D_POS];
    if (isMisc && (word[NOP_LOW_HI:0] == '0)) begin
      normWord[X_NOP_HI:X_NOP_LO] = '0;
    end
    if ((top == TOP_BYTE) && (op == OPB_CLR) && !word[D_POS]) begin
      normWord[FA_HI:0] = '0;
    end
    if ((top == TOP_LIT) && (((op & OPL_PAIR_MASK) == OPL_MOVE) || ((op & OPL_PAIR_MASK) == OPL_RETL))) begin
      normWord[X_LIT_HI:X_LIT_LO] = '0;
    end
    if ((top == TOP_LIT) && (((op & OPL_ONE_MASK) == OPL_SUBL) || ((op & OPL_ONE_MASK) == OPL_ADDL))) begin
      normWord[X_LIT_LO] = 1'b0;
    end
    // opcode and operand fields; seven-bit file address
    fileAddr = normWord[FA_HI:0];
    destSel = normWord[D_POS];
    bitSel = normWord[BIT_HI:BIT_LO];
    lit8 = normWord[LIT8_W-1:0];
    lit11 = normWord[LIT11_W-1:0];
    namesFile = (top == TOP_BIT) || ((top == TOP_BYTE) && !isMisc && !((op == OPB_CLR) && !word[D_POS]));
    writesFile = ((top == TOP_BYTE) && namesFile && destSel) || ((top == TOP_BIT) && !word[BIT_TEST_POS]);
    writesAcc = ((top == TOP_BYTE) && !destSel && (op != OPB_MISC)) || (top == TOP_LIT);
    if (top == TOP_BYTE) begin
      if (op == OPB_MISC) begin
        affectsStatus = isMisc && ((normWord == WORD_SLEEP) || (normWord == WORD_WDTCLR));
      end else begin
        affectsStatus = (op != OPB_SWAP) && (op != OPB_DECSZ) && (op != OPB_INCSZ);
      end
    end else if (top == TOP_LIT) begin
      affectsStatus = ((op & OPL_PAIR_MASK) != OPL_MOVE) && ((op & OPL_PAIR_MASK) != OPL_RETL);
    end else begin
      affectsStatus = 1'b0;
    end
    isSkip = ((top == TOP_BYTE) && ((op == OPB_DECSZ) || (op == OPB_INCSZ))) ||
             ((top == TOP_BIT) && word[BIT_TEST_POS]);
    changesPc = (top == TOP_JUMP) || ((top == TOP_LIT) && ((op & OPL_PAIR_MASK) == OPL_RETL)) ||
                (isMisc && ((normWord == WORD_RETURN) || (normWord == WORD_RETINT)));
  end
endmodule

// file: verification/iwd_prog_mem.sv
// Program memory model that hands the decoder one word per instruction cycle.
`timescale 1ns/100ps
module iwd_prog_mem
  import iwd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fetch side
  input wire logic fetchStrb,
  output logic [iwd_pkg::INSN_W-1:0] insnWord
);
  logic [iwd_pkg::INSN_W-1:0] mem [0:255];
  logic [7:0] addr_ff;
  ////////////////////////////////////////
  // The fetch address is kept sequential: flushed words are still fetched and then discarded by the core.
  assign insnWord = mem[addr_ff];
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_ff <= 8'h00;
    end else if (fetchStrb) begin
      addr_ff <= addr_ff + 8'h01;
    end
  end
endmodule

// file: verification/test_insn_word_decode_timing.sv
// Self-checking bench for the instruction decoder against a reference built from the fetched words.
`timescale 1ns/100ps
module test_insn_word_decode_timing;
  import iwd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic skipTaken = 1'b0;
  logic prescToTimer = 1'b0;
  logic [13:0] insnWord, normWord, w, nw;
  iwd_fmt_t fmt, ef;
  iwd_phase_t phase;
  logic [6:0] fileAddr, fa;
  logic [2:0] bitSel;
  logic [7:0] bitMask, lit8;
  logic [10:0] lit11;
  logic [3:0] op;
  logic destSel, fileRdStrb, readPins, fileWrStrb, accWrStrb, statusWrStrb, pcLoad, prescClr, fetchStrb, nopCycle;
  logic byt, bt, lit, d, nf, fw, aw, st, skp, pc, fl, tk, pr;
  int err_total = 0;
  int n_tests = 0;
  localparam logic [15:0] BYTE_ST = 16'h37fe;
  localparam logic [15:0] LIT_ST = 16'hf700;

  iwd_decoder u_iwd_decoder (.clk, .rst, .insnWord, .skipTaken, .prescToTimer, .fmt, .normWord, .fileAddr,
    .destSel, .bitSel, .bitMask, .lit8, .lit11, .phase, .fileRdStrb, .readPins, .fileWrStrb, .accWrStrb,
    .statusWrStrb, .pcLoad, .prescClr, .fetchStrb, .nopCycle);
  iwd_prog_mem u_iwd_prog_mem (.clk, .rst, .fetchStrb, .insnWord);

  initial begin
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic chkF(string nm, logic [13:0] e, logic [13:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkS(string nm, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Random words, biased towards the addresses and words with side effects; undefined codes are avoided.
  function automatic logic [13:0] gen();
    logic [13:0] g;
    g = 14'($urandom);
    case ($urandom % 8)
      0: g[6:0] = 7'h01;
      1: g[6:0] = 7'h02;
      2: g[6:0] = 7'(5 + $urandom % 5);
      3: g = {6'h01, 1'b0, 7'($urandom)};
      4: g = ($urandom % 2) ? WORD_SLEEP : WORD_WDTCLR;
      5: g = ($urandom % 2) ? WORD_RETURN : WORD_RETINT;
      6: g = {7'h00, 2'($urandom), 5'h00};
      default: ;
    endcase
    if (g[13:7] == 7'h00 && g[4:0] != 5'h00 && !(g inside {WORD_RETURN, WORD_RETINT, WORD_SLEEP, WORD_WDTCLR}))
      g[4:0] = 5'h00;
    if (g[13:12] == 2'h3 && g[11:8] == 4'hb)
      g[10] = 1'b1;
    return g;
  endfunction

  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hbb11));
    for (int i = 0; i < 256; i++) u_iwd_prog_mem.mem[i] = gen();
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    fl = 1'b1;
    for (int n = 0; n < 600; n++) begin
      w = (n == 0) ? 14'h0000 : u_iwd_prog_mem.mem[8'(n - 1)];
      op = w[11:8];
      d = w[7];
      fa = w[6:0];
      byt = w[13:12] == 2'h0;
      bt = w[13:12] == 2'h1;
      lit = w[13:12] == 2'h3;
      ef = byt ? FMT_BYTE : (bt ? FMT_BIT : FMT_LIT);
      nf = bt || (byt && op != 4'h0 && !(op == 4'h1 && !d)) || (byt && op == 4'h0 && d);
      fw = (byt && d) || (bt && !op[3]);
      aw = (byt && !d && op != 4'h0) || lit;
      st = (byt && BYTE_ST[op]) || (lit && LIT_ST[op]) || w == WORD_SLEEP || w == WORD_WDTCLR;
      skp = (byt && (op == 4'hb || op == 4'hf)) || (bt && op[3]);
      pc = w[13:12] == 2'h2 || w == WORD_RETURN || w == WORD_RETINT || (lit && op[3:2] == 2'h1) || (fw && fa == 7'h02);
      nw = w;
      if (w[13:7] == 7'h00 && w[4:0] == 5'h00) nw[6:5] = 2'h0;
      if (byt && op == 4'h1 && !d) nw[6:0] = 7'h00;
      if (lit && !op[3]) nw[9:8] = 2'h0;
      if (lit && op[3:2] == 2'h3) nw[8] = 1'b0;
      @(posedge clk);
      #1;
      chkF("phase", 14'(PH_Q2), 14'(phase));
      chkS("nopCycle", fl, nopCycle);
      chkS("fileRdStrb", !fl && nf, fileRdStrb);
      chkS("readPins", !fl && nf && fa >= 7'h05 && fa <= 7'h09, readPins);
      if (!fl) chkF("fmt", 14'(ef), 14'(fmt));
      if (!fl) chkF("normWord", nw, normWord);
      if (!fl && nf) chkF("fileAddr", 14'(fa), 14'(fileAddr));
      if (!fl && byt) chkS("destSel", d, destSel);
      if (!fl && bt) chkF("bitSel", 14'(w[9:7]), 14'(bitSel));
      if (!fl && bt) chkF("bitMask", 14'(8'h01 << w[9:7]), 14'(bitMask));
      if (!fl && lit) chkF("lit8", 14'(w[7:0]), 14'(lit8));
      if (!fl && w[13:12] == 2'h2) chkF("lit11", 14'(w[10:0]), 14'(lit11));
      @(posedge clk);
      tk = 1'($urandom);
      pr = 1'($urandom);
      skipTaken <= tk;
      prescToTimer <= pr;
      @(posedge clk);
      #1;
      chkF("phase", 14'(PH_Q4), 14'(phase));
      chkS("fetchStrb", 1'b1, fetchStrb);
      chkS("fileWrStrb", !fl && fw, fileWrStrb);
      chkS("accWrStrb", !fl && aw, accWrStrb);
      chkS("statusWrStrb", !fl && st, statusWrStrb);
      chkS("pcLoad", !fl && pc, pcLoad);
      chkS("prescClr", !fl && fw && fa == 7'h01 && pr, prescClr);
      chkS("nopCycle", fl, nopCycle);
      fl = !fl && (pc || (skp && tk));
      @(posedge clk);
    end
    results();
  end

  // A hang ends the run through the same verdict.
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    results();
  end
endmodule
